// ---- logic/rcif_pkg.sv ----
package rcif_pkg;

  // ----------------------------------------------------------------
  // Command inputs, one bit each on the contact pins
  // ----------------------------------------------------------------
  localparam int NUM_CMD = 9;
  localparam int CMD_AUTOMATIC_POWER_CONTROL_ON = 0;
  localparam int CMD_FIL_ON = 1;
  localparam int CMD_FIL_OFF = 2;
  localparam int CMD_HV_ON = 3;
  localparam int CMD_HV_OFF = 4;
  localparam int CMD_RAISE = 5;
  localparam int CMD_LOWER = 6;
  localparam int CMD_PRESET = 7;
  localparam int CMD_OVL_RST = 8;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 50;
  localparam int DEBOUNCE_US = 10;
  localparam int DEBOUNCE_CYC = DEBOUNCE_US * CLK_MHZ;
  localparam int DBC_W = 10;

  // ----------------------------------------------------------------
  // Register map (byte addresses) and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_POWER = 8'h08;
  localparam logic [7:0] ADDR_CMD = 8'h0c;
  localparam int CTRL_POL_BIT = 0;
  localparam int CTRL_RDIS_BIT = 1;
  localparam int CTRL_LOG_LSB = 2;
  localparam int CMD_AUTOMATIC_POWER_CONTROL_OFF_BIT = 0;
  localparam int NUM_METER = 5;
  localparam int PWR_W = 8;

  // ----------------------------------------------------------------
  // Values after reset, and the power level limits
  // ----------------------------------------------------------------
  localparam logic POL_RESET = 1'b0;
  localparam logic RDIS_RESET = 1'b0;
  localparam logic [4:0] LOG_RESET = 5'h00;
  localparam logic [7:0] POWER_RESET = 8'h80;
  localparam logic [7:0] POWER_MAX = 8'hff;
  localparam logic [7:0] POWER_MIN = 8'h00;

  // Overload order inside the four-bit vectors
  localparam int OVL_PLATE = 0;
  localparam int OVL_SCREEN = 1;
  localparam int OVL_GRID = 2;
  localparam int OVL_REFL = 3;

  // Plant sense inputs, high while true
  typedef struct packed {
    logic failsafe_closed;
    logic interlock_closed;
    logic blower_on;
    logic fil_contactor;
    logic hv_contactor;
    logic [3:0] overload_detect;
  } rcif_plant_s;

  // Status pins toward the remote unit, low while true
  typedef struct packed {
    logic automatic_power_control_n;
    logic fil_on_n;
    logic remote_dis_n;
    logic hv_on_n;
    logic [3:0] ovl_n;
    logic ovl_any_n;
    logic preset_n;
    logic failsafe_n;
    logic interlock_n;
    logic blower_n;
    logic fil_ctr_n;
    logic hv_ctr_n;
  } rcif_status_s;

endpackage

// ---- logic/rcif_cmd_filter.sv ----
module rcif_cmd_filter (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Contact pin and polarity
  input wire logic pin,
  input wire logic polarity_neg,
  // Cleaned command
  output logic asserted,
  output logic rise
);
  import rcif_pkg::*;

  logic sync1;
  logic sync2;
  logic [DBC_W-1:0] cnt;
  logic [DBC_W-1:0] next_cnt;
  logic next_asserted;
  logic next_rise;
  logic sample;

  // Two-stage synchroniser; only sync2 is read
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
    end else begin
      sync1 <= pin;
      sync2 <= sync1;
    end
  end

  // Debounce: level must hold for the whole window
  // Changing polarity flips the sample and may look like a press
  always_comb begin
    sample = sync2 ^ polarity_neg;
    next_cnt = '0;
    next_asserted = asserted;
    next_rise = 1'b0;
    if (sample != asserted) begin
      if (cnt == DBC_W'(DEBOUNCE_CYC - 1)) begin
        next_asserted = sample;
        next_rise = sample;
      end else begin
        next_cnt = cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= '0;
      asserted <= 1'b0;
      rise <= 1'b0;
    end else begin
      cnt <= next_cnt;
      asserted <= next_asserted;
      rise <= next_rise;
    end
  end

endmodule

// ---- logic/rcif_overload.sv ----
module rcif_overload (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Detectors and clear
  input wire logic [3:0] detect,
  input wire logic clear,
  // Latched faults
  output logic [3:0] latched
);
  import rcif_pkg::*;

  logic [3:0] next_latched;

  // A fault present in the clear cycle stays latched
  always_comb begin
    next_latched = detect | (latched & ~{4{clear}});
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      latched <= '0;
    end else begin
      latched <= next_latched;
    end
  end

endmodule

// ---- logic/rcif_top.sv ----
// How it works
// - Polarity bit picks high-active or low-active contacts; high-active after reset.
// - Filament-off press turns filaments off and high voltage off too.
// - High-voltage-on press turns high voltage on and filaments on too.
// - Power-control-on press enables automatic power control.
// - High-voltage-off press turns high voltage off.
// - Raise press steps power level up by one.
// - Lower press steps power level down by one.
// - Preset on only while held, power control on, remote not disabled.
// - Releasing preset returns to full power with no other command.
// - Overload-reset press clears the latched overloads.
// - Power-control status pin low while power control is on.
// - Filament status pin low while filaments are enabled.
// - Remote-disabled pin low while remote commands are disabled.
// - High-voltage status pin low while high voltage is enabled.
// - Four overload pins, each low while its overload is latched.
// - Summary overload pin low while any overload is latched.
// - Preset status pin low while preset power is on.
// - Failsafe and interlock pins low while each loop is closed.
// - Blower pin low while the blower runs.
// - Contactor pins low while filament or high voltage contactor is energised.
// - Each meter sample has a log/linear select, linear after reset.
//
// Chosen here: register access over APB and the register offsets.
module rcif_top (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Remote contacts and plant sense
  input wire logic [rcif_pkg::NUM_CMD-1:0] cmd_pin,
  input wire rcif_pkg::rcif_plant_s plant_pin,
  // Status pins toward the remote unit
  output rcif_pkg::rcif_status_s status_n,
  // Transmitter control
  output logic automatic_power_control,
  output logic fil_enable,
  output logic hv_enable,
  output logic preset_enable,
  output logic [rcif_pkg::PWR_W-1:0] power_level,
  output logic overload_clear,
  output logic [rcif_pkg::NUM_METER-1:0] meter_log
);
  import rcif_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [NUM_CMD-1:0] cmd_level;
  logic [NUM_CMD-1:0] cmd_rise;
  logic [NUM_CMD-1:0] cmd_go;
  rcif_plant_s plant_s1;
  rcif_plant_s plant_s2;
  logic [3:0] ovl_latched;
  logic polarity_neg;
  logic remote_dis;
  logic next_polarity_neg;
  logic next_remote_dis;
  logic [NUM_METER-1:0] next_meter_log;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic setup;
  logic wr_fire;
  logic mapped;
  logic sw_automatic_power_control_off;
  logic sw_power_wr;
  logic next_automatic_power_control;
  logic next_fil_enable;
  logic next_hv_enable;
  logic next_preset_enable;
  logic [PWR_W-1:0] next_power_level;
  logic next_overload_clear;
  rcif_status_s next_status_n;

  // ----------------------------------------------------------------
  // Command inputs
  // ----------------------------------------------------------------
  // One filter per contact
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CMD; gi++) begin : g_cmd
      rcif_cmd_filter u_filter (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .pin(cmd_pin[gi]),
        .polarity_neg(polarity_neg),
        .asserted(cmd_level[gi]),
        .rise(cmd_rise[gi])
      );
    end
  endgenerate

  // Presses are dropped while remote control is disabled
  assign cmd_go = cmd_rise & {NUM_CMD{~remote_dis}};

  // Plant sense pins come from outside the clock domain
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      plant_s1 <= '0;
      plant_s2 <= '0;
    end else begin
      plant_s1 <= plant_pin;
      plant_s2 <= plant_s1;
    end
  end

  // Overload latches, cleared by the reset press
  rcif_overload u_overload (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .detect(plant_s2.overload_detect),
    .clear(cmd_go[CMD_OVL_RST]),
    .latched(ovl_latched)
  );

  // ----------------------------------------------------------------
  // APB register file
  // ----------------------------------------------------------------
  // Answer is registered: pready rises in the first access cycle
  always_comb begin
    setup = psel & ~penable;
    wr_fire = psel & penable & pready & pwrite;
    mapped = (paddr == ADDR_CTRL) | (paddr == ADDR_STATUS) |
             (paddr == ADDR_POWER) | (paddr == ADDR_CMD);
    next_pready = setup;
    next_pslverr = setup & ~mapped;
    next_prdata = '0;
    if (setup && !pwrite) begin
      case (paddr)
        ADDR_CTRL: begin
          next_prdata[CTRL_POL_BIT] = polarity_neg;
          next_prdata[CTRL_RDIS_BIT] = remote_dis;
          next_prdata[CTRL_LOG_LSB +: NUM_METER] = meter_log;
        end
        ADDR_STATUS: begin
          next_prdata[0] = automatic_power_control;
          next_prdata[1] = fil_enable;
          next_prdata[2] = hv_enable;
          next_prdata[3] = preset_enable;
          next_prdata[7:4] = ovl_latched;
          next_prdata[8] = plant_s2.failsafe_closed;
          next_prdata[9] = plant_s2.interlock_closed;
          next_prdata[10] = plant_s2.blower_on;
          next_prdata[11] = plant_s2.fil_contactor;
          next_prdata[12] = plant_s2.hv_contactor;
          next_prdata[13] = remote_dis;
        end
        ADDR_POWER: begin
          next_prdata[PWR_W-1:0] = power_level;
        end
        default: begin
          next_prdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // Writable configuration; writes land on the pready edge only
  always_comb begin
    next_polarity_neg = polarity_neg;
    next_remote_dis = remote_dis;
    next_meter_log = meter_log;
    sw_automatic_power_control_off = 1'b0;
    sw_power_wr = 1'b0;
    if (wr_fire) begin
      case (paddr)
        ADDR_CTRL: begin
          next_polarity_neg = pwdata[CTRL_POL_BIT];
          next_remote_dis = pwdata[CTRL_RDIS_BIT];
          next_meter_log = pwdata[CTRL_LOG_LSB +: NUM_METER];
        end
        ADDR_POWER: begin
          sw_power_wr = 1'b1;
        end
        ADDR_CMD: begin
          sw_automatic_power_control_off = pwdata[CMD_AUTOMATIC_POWER_CONTROL_OFF_BIT];
        end
        default: begin
          sw_power_wr = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      polarity_neg <= POL_RESET;
      remote_dis <= RDIS_RESET;
      meter_log <= LOG_RESET;
    end else begin
      polarity_neg <= next_polarity_neg;
      remote_dis <= next_remote_dis;
      meter_log <= next_meter_log;
    end
  end

  // ----------------------------------------------------------------
  // Transmitter control state
  // ----------------------------------------------------------------
  // Off commands beat on commands in the same cycle for filament and high voltage; the power-control-on press beats the software off
  always_comb begin
    next_automatic_power_control = automatic_power_control;
    if (cmd_go[CMD_AUTOMATIC_POWER_CONTROL_ON]) begin
      next_automatic_power_control = 1'b1;
    end else if (sw_automatic_power_control_off) begin
      next_automatic_power_control = 1'b0;
    end
    next_hv_enable = hv_enable;
    if (cmd_go[CMD_HV_OFF] || cmd_go[CMD_FIL_OFF]) begin
      next_hv_enable = 1'b0;
    end else if (cmd_go[CMD_HV_ON]) begin
      next_hv_enable = 1'b1;
    end
    next_fil_enable = fil_enable;
    if (cmd_go[CMD_FIL_OFF]) begin
      next_fil_enable = 1'b0;
    end else if (cmd_go[CMD_FIL_ON] || cmd_go[CMD_HV_ON]) begin
      next_fil_enable = 1'b1;
    end
    // Held level, so release drops straight back to full power
    next_preset_enable = cmd_level[CMD_PRESET] & automatic_power_control & ~remote_dis;
    next_overload_clear = cmd_go[CMD_OVL_RST];
    // Steps saturate; a software write wins over a press
    next_power_level = power_level;
    if (sw_power_wr) begin
      next_power_level = pwdata[PWR_W-1:0];
    end else if (cmd_go[CMD_RAISE] && !cmd_go[CMD_LOWER] && power_level != POWER_MAX) begin
      next_power_level = power_level + 1'b1;
    end else if (cmd_go[CMD_LOWER] && !cmd_go[CMD_RAISE] && power_level != POWER_MIN) begin
      next_power_level = power_level - 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      automatic_power_control <= 1'b0;
      fil_enable <= 1'b0;
      hv_enable <= 1'b0;
      preset_enable <= 1'b0;
      overload_clear <= 1'b0;
      power_level <= POWER_RESET;
    end else begin
      automatic_power_control <= next_automatic_power_control;
      fil_enable <= next_fil_enable;
      hv_enable <= next_hv_enable;
      preset_enable <= next_preset_enable;
      overload_clear <= next_overload_clear;
      power_level <= next_power_level;
    end
  end

  // ----------------------------------------------------------------
  // Status pins, low while true
  // ----------------------------------------------------------------
  always_comb begin
    next_status_n.automatic_power_control_n = ~automatic_power_control;
    next_status_n.fil_on_n = ~fil_enable;
    next_status_n.remote_dis_n = ~remote_dis;
    next_status_n.hv_on_n = ~hv_enable;
    next_status_n.ovl_n = ~ovl_latched;
    next_status_n.ovl_any_n = ~(|ovl_latched);
    next_status_n.preset_n = ~preset_enable;
    next_status_n.failsafe_n = ~plant_s2.failsafe_closed;
    next_status_n.interlock_n = ~plant_s2.interlock_closed;
    next_status_n.blower_n = ~plant_s2.blower_on;
    next_status_n.fil_ctr_n = ~plant_s2.fil_contactor;
    next_status_n.hv_ctr_n = ~plant_s2.hv_contactor;
  end

  // Everything off shows as high pins during reset
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      status_n <= '1;
    end else begin
      status_n <= next_status_n;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  sequence s_fil_off_press;
    cmd_rise[CMD_FIL_OFF] && !remote_dis;
  endsequence

  sequence s_hv_on_press;
    cmd_rise[CMD_HV_ON] && !remote_dis && !cmd_rise[CMD_FIL_OFF] && !cmd_rise[CMD_HV_OFF];
  endsequence

  a_fil_off_all: assert property (s_fil_off_press |=> !fil_enable && !hv_enable ##1 status_n.fil_on_n)
    else $error("filament off press left filament or high voltage on");
  a_hv_on_both: assert property (s_hv_on_press |=> hv_enable && fil_enable ##1 !status_n.hv_on_n)
    else $error("high voltage on press did not enable both");
  a_auto_on_press: assert property (cmd_rise[CMD_AUTOMATIC_POWER_CONTROL_ON] && !remote_dis |=>
                                    automatic_power_control)
    else $error("power control on press ignored");
  a_hv_off_press: assert property (cmd_rise[CMD_HV_OFF] && !remote_dis |=> !hv_enable)
    else $error("high voltage off press ignored");
  a_raise_step: assert property (cmd_go[CMD_RAISE] && !cmd_go[CMD_LOWER] && !sw_power_wr &&
                                 power_level != POWER_MAX |=> power_level == $past(power_level) + 8'h01)
    else $error("raise did not step power up by one");
  a_lower_step: assert property (cmd_go[CMD_LOWER] && !cmd_go[CMD_RAISE] && !sw_power_wr &&
                                 power_level != POWER_MIN |=> power_level == $past(power_level) - 8'h01)
    else $error("lower did not step power down by one");
  a_preset_gate: assert property (preset_enable |->
                                  $past(cmd_level[CMD_PRESET] && automatic_power_control && !remote_dis))
    else $error("preset enabled without its conditions");
  a_preset_release: assert property ($fell(cmd_level[CMD_PRESET]) |=> !preset_enable ##1 status_n.preset_n)
    else $error("preset held after release");
  a_ovl_clear: assert property (cmd_go[CMD_OVL_RST] && plant_s2.overload_detect == 4'h0 |=>
                                overload_clear && ovl_latched == 4'h0)
    else $error("overload reset did not clear latches");
  a_status_auto: assert property (##1 status_n.automatic_power_control_n == !$past(automatic_power_control))
    else $error("power control status pin wrong");
  a_status_rdis: assert property (##1 status_n.remote_dis_n == !$past(remote_dis))
    else $error("remote disabled pin wrong");
  a_ovl_pins: assert property (##1 status_n.ovl_n == ~$past(ovl_latched))
    else $error("overload pin does not follow latch");
  a_ovl_summary: assert property (status_n.ovl_any_n == &status_n.ovl_n)
    else $error("summary overload pin disagrees");
  a_plant_pins: assert property (##1 status_n.failsafe_n == !$past(plant_s2.failsafe_closed) &&
                                 status_n.blower_n == !$past(plant_s2.blower_on))
    else $error("plant status pins wrong");
  a_cmd_pulse: assert property (|cmd_rise |=> (cmd_rise & $past(cmd_rise)) == '0)
    else $error("command pulse longer than one cycle");

endmodule

// ---- bench/rcif_remote_unit.sv ----
module rcif_remote_unit (
  // Clock and selected polarity
  input wire logic ref_clk,
  input wire logic polarity_neg,
  // Contact pins toward the controller
  output logic [rcif_pkg::NUM_CMD-1:0] cmd_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  import rcif_pkg::*;

  // ----------------------------------------------------------------
  // Contact closures
  // ----------------------------------------------------------------
  // Rides out the synchroniser plus the debounce window
  localparam int HOLD = DEBOUNCE_CYC + 20;
  logic [NUM_CMD-1:0] closed = '0;

  // Closed reads as supply when positive, ground when negative
  assign cmd_pin = closed ^ {NUM_CMD{polarity_neg}};

  // Momentary press; a short len models contact bounce
  task automatic press(input int idx, input int len = HOLD);
    @(posedge ref_clk);
    closed[idx] <= 1'b1;
    repeat (len) @(posedge ref_clk);
    closed[idx] <= 1'b0;
    repeat (HOLD) @(posedge ref_clk);
  endtask

  // Preset contact is held, never pulsed
  task automatic hold_preset(input logic on);
    @(posedge ref_clk);
    closed[CMD_PRESET] <= on;
    repeat (HOLD) @(posedge ref_clk);
  endtask
endmodule

// ---- bench/tb_top.sv ----
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import rcif_pkg::*;

  // ----------------------------------------------------------------
  // Signals and case table
  // ----------------------------------------------------------------
  typedef struct {
    int cmd;
    logic [2:0] en;
    logic [7:0] pwr;
  } rcif_row_s;
  // Whole run needs roughly 18k cycles
  localparam int LIMIT = 60000;
  logic ref_clk, rstn, psel, penable, pwrite, pol_neg, pready, pslverr, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [NUM_CMD-1:0] cmd_pin;
  rcif_plant_s plant;
  rcif_status_s status_n;
  logic automatic_power_control, fil_enable, hv_enable, preset_enable, overload_clear;
  logic [PWR_W-1:0] power_level;
  logic [NUM_METER-1:0] meter_log;
  logic [4:0] pat;
  int err_count = 0;
  int tests_run = 0;
  int cyc = 0;
  int clr_cnt = 0;
  // Expected {power control, fil, hv} and power after each press
  rcif_row_s rows [8] = '{
    '{CMD_AUTOMATIC_POWER_CONTROL_ON, 3'h4, 8'h80}, '{CMD_HV_ON, 3'h7, 8'h80}, '{CMD_HV_OFF, 3'h6, 8'h80},
    '{CMD_HV_ON, 3'h7, 8'h80}, '{CMD_FIL_OFF, 3'h4, 8'h80}, '{CMD_FIL_ON, 3'h6, 8'h80},
    '{CMD_RAISE, 3'h6, 8'h81}, '{CMD_LOWER, 3'h6, 8'h80}};

  rcif_top u_dut (
    .ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmd_pin(cmd_pin), .plant_pin(plant), .status_n(status_n),
    .automatic_power_control(automatic_power_control),
    .fil_enable(fil_enable), .hv_enable(hv_enable), .preset_enable(preset_enable),
    .power_level(power_level), .overload_clear(overload_clear), .meter_log(meter_log)
  );
  rcif_remote_unit u_remote (.ref_clk(ref_clk), .polarity_neg(pol_neg), .cmd_pin(cmd_pin));

  // Clock, hang guard, clear-pulse counter
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // Counted mid-cycle, clear of the edge that moves the pulse
  always @(negedge ref_clk) begin
    cyc++;
    if (overload_clear === 1'b1) clr_cnt++;
    if (cyc == LIMIT) begin
      err_count++;
      print_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  // APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    // Answer looked at mid-cycle; only the hang guard ends the wait
    @(negedge ref_clk);
    while (pready !== 1'b1) begin
      @(negedge ref_clk);
    end
    rd = prdata;
    er = pslverr;
    @(posedge ref_clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic done(input string name);
    $display("%s finished", name);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    pol_neg = 1'b0;
    plant = '0;
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
    foreach (rows[i]) begin
      u_remote.press(rows[i].cmd);
      chk("enables", rows[i].en, {automatic_power_control, fil_enable, hv_enable});
      chk("status", 3'(~rows[i].en), {status_n.automatic_power_control_n,
        status_n.fil_on_n, status_n.hv_on_n});
      chk("power", rows[i].pwr, power_level);
    end
    done("table");
    // Second reset in mid-run
    @(posedge ref_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk("rst_status", 15'h7fff, status_n);
    chk("rst_power", 8'h80, power_level);
    chk("rst_out", 10'h000, {automatic_power_control, fil_enable, hv_enable, preset_enable,
      overload_clear, meter_log});
    repeat (18) @(posedge ref_clk);
    rstn <= 1'b1;
    apb(1'b0, ADDR_CTRL, 32'h0000_0000);
    chk("ctrl_reset", 32'h0000_0000, rd);
    u_remote.press(CMD_HV_ON, 100);
    chk("bounce", 1'b0, hv_enable);
    done("reset");
    // Power at the top stays put; unmapped access refused
    apb(1'b1, ADDR_POWER, 32'h0000_00ff);
    u_remote.press(CMD_RAISE);
    chk("power_sat", 8'hff, power_level);
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk("unmapped", 1'b1, er);
    done("power");
    // Preset follows the held contact
    u_remote.press(CMD_AUTOMATIC_POWER_CONTROL_ON);
    u_remote.hold_preset(1'b1);
    chk("preset_on", 2'h2, {preset_enable, status_n.preset_n});
    u_remote.hold_preset(1'b0);
    chk("preset_off", 2'h1, {preset_enable, status_n.preset_n});
    // Remote disable blocks preset and presses
    apb(1'b1, ADDR_CTRL, 32'h0000_0002);
    u_remote.hold_preset(1'b1);
    chk("dis_pin", 1'b0, status_n.remote_dis_n);
    chk("dis_preset", 1'b0, preset_enable);
    u_remote.hold_preset(1'b0);
    u_remote.press(CMD_HV_ON);
    chk("dis_hv", 1'b0, hv_enable);
    apb(1'b1, ADDR_CTRL, 32'h0000_0000);
    done("preset");
    // Short overload pulse latches until reset press
    @(posedge ref_clk);
    plant <= 9'h005;
    repeat (4) @(posedge ref_clk);
    plant <= '0;
    repeat (6) @(posedge ref_clk);
    chk("ovl_latch", 5'h14, {status_n.ovl_n, status_n.ovl_any_n});
    clr_cnt = 0;
    u_remote.press(CMD_OVL_RST);
    chk("clr_pulses", 32'h0000_0001, clr_cnt);
    chk("ovl_clear", 5'h1f, {status_n.ovl_n, status_n.ovl_any_n});
    done("overload");
    // Plant indications, two opposite patterns
    for (int k = 0; k < 2; k++) begin
      pat = k ? 5'h0a : 5'h15;
      @(posedge ref_clk);
      plant <= {pat, 4'h0};
      repeat (6) @(posedge ref_clk);
      chk("plant", 5'(~pat), {status_n.failsafe_n, status_n.interlock_n, status_n.blower_n,
        status_n.fil_ctr_n, status_n.hv_ctr_n});
    end
    done("plant");
    // Negative polarity with log meters; idle pins follow within a cycle
    apb(1'b1, ADDR_CTRL, 32'h0000_0059);
    pol_neg <= 1'b1;
    repeat (600) @(posedge ref_clk);
    chk("neg_idle", 3'h4, {automatic_power_control, fil_enable, hv_enable});
    chk("meter_log", 5'h16, meter_log);
    u_remote.press(CMD_HV_ON);
    chk("neg_on", 3'h7, {automatic_power_control, fil_enable, hv_enable});
    u_remote.press(CMD_HV_OFF);
    chk("neg_off", 3'h6, {automatic_power_control, fil_enable, hv_enable});
    done("polarity");
    // Register views, then software switch-off of power control
    apb(1'b0, ADDR_STATUS, 32'h0000_0000);
    chk("status_reg", 32'h0000_0a03, rd);
    apb(1'b0, ADDR_POWER, 32'h0000_0000);
    chk("power_reg", 32'h0000_00ff, rd);
    apb(1'b1, ADDR_CMD, 32'h0000_0001);
    repeat (2) @(negedge ref_clk);
    chk("sw_off", 2'h1, {automatic_power_control, status_n.automatic_power_control_n});
    done("registers");
    print_verdict();
  end
endmodule
